// file: dce_defines.vh
// Register map, field positions, reset values and timing counts
`ifndef DCE_DEFINES_VH
`define DCE_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DCE_OFS_CTRL   8'h00
`define DCE_OFS_STAT   8'h04
`define DCE_OFS_SRC0   8'h10
`define DCE_OFS_DST0   8'h14
`define DCE_OFS_DCTL0  8'h18
`define DCE_OFS_SRC1   8'h20
`define DCE_OFS_DST1   8'h24
`define DCE_OFS_DCTL1  8'h28
// ----------------------------------------
// Channel control fields
// ----------------------------------------
`define DCE_CTRL_EN    0
`define DCE_CTRL_TRIGE 1
`define DCE_CTRL_PRIO  3:2
`define DCE_CTRL_NDESC 4
`define DCE_CTRL_NEXT  5
`define DCE_CTRL_SWT   8
`define DCE_PRIO_RST   2'h3
// ----------------------------------------
// Descriptor control fields
// ----------------------------------------
`define DCE_D_CNT      15:0
`define DCE_D_ESIZE    17:16
`define DCE_D_SWORD    18
`define DCE_D_DWORD    19
`define DCE_D_SINC     20
`define DCE_D_DINC     21
`define DCE_D_TTYPE    23:22
`define DCE_D_MODE     25:24
`define DCE_D_PREEMPT  26
`define DCE_D_CHAIN    27
`define DCE_D_INVAL    28
`define DCE_D_IRQ      29
`define DCE_D_VALID    31
`define DCE_DCTL_RST   32'h000f0000
// ----------------------------------------
// Encodings
// ----------------------------------------
`define DCE_SZ_BYTE    2'h0
`define DCE_SZ_HALF    2'h1
`define DCE_SZ_WORD    2'h2
`define DCE_TT_PULSE   2'h0
`define DCE_TT_LVL4    2'h1
`define DCE_TT_LVL8    2'h2
`define DCE_TT_UNK     2'h3
`define DCE_MD_SINGLE  2'h0
`define DCE_MD_DESCR   2'h1
`define DCE_MD_CHAIN   2'h2
// ----------------------------------------
// Timing counts in system clock cycles
// ----------------------------------------
`define DCE_WAIT_LVL4  4'h4
`define DCE_WAIT_LVL8  4'h8
`define DCE_TRO_CYC    2'h2
`endif

// file: dce_channel.v
// One DMA channel with two descriptors and an AHB-Lite register slave
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "dce_defines.vh"

//
// Contract
// - Hardware trigger only when input enabled
// - Priority setting, zero highest, reset three
// - One element per transfer, size selectable
// - Element count one to 65536, default one
// - Independent source/destination width sets step
// - Element narrower than word location allowed
// - Source address advances by source width
// - Destination advances by destination width
// - Level type one waits four cycles
// - Level type two waits eight cycles
// - Unknown pulse needs trigger low again
// - Count wait or drop, then retrigger
// - Single mode moves one element per trigger
// - Descriptor mode moves all elements
// - Chain mode forces chain, auto triggers
// - Preemptable descriptor yields, stays pending
// - Chain action selects other descriptor next
// - Invalidate clears valid bit at end
// - Interrupt request at descriptor end
// - Run only descriptors enabled by count
// - Completion output pulse two cycles high
// - Busy triggers collapse into one pending
// - Invalid descriptor disables the channel
module dce_channel #(
  parameter [4:0] CHAN_ID = 5'h00
) (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        reset_n_i,
  // AHB-Lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  // Trigger pins
  input  wire        trigger_input_i,
  output reg         completion_trigger_output_o,
  output reg         irq_req_o,
  // Arbitration view of the competing channel
  input  wire        arb_req_i,
  input  wire [1:0]  arb_prio_i,
  input  wire [4:0]  arb_chan_i,
  // System bus master
  output reg         mem_req_o,
  output reg         mem_we_o,
  output reg  [31:0] mem_addr_o,
  output reg  [1:0]  mem_size_o,
  output reg  [31:0] mem_wdata_o,
  input  wire        mem_ack_i,
  input  wire [31:0] mem_rdata_i
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RD   = 2'h1;
  localparam [1:0] S_WR   = 2'h2;
  localparam [1:0] S_NEXT = 2'h3;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [2:0] dce_step;
    input [1:0] esize;
    input       wordw;
    begin
      if (wordw)
        dce_step = 3'h4;
      else if (esize == `DCE_SZ_BYTE)
        dce_step = 3'h1;
      else if (esize == `DCE_SZ_HALF)
        dce_step = 3'h2;
      else
        dce_step = 3'h4;
    end
  endfunction

  function [31:0] dce_mask;
    input [1:0] esize;
    begin
      if (esize == `DCE_SZ_BYTE)
        dce_mask = 32'h000000ff;
      else if (esize == `DCE_SZ_HALF)
        dce_mask = 32'h0000ffff;
      else
        dce_mask = 32'hffffffff;
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [31:0] src_r [0:1];
  reg [31:0] dst_r [0:1];
  reg [31:0] dctl_r [0:1];
  reg        en_r;
  reg        trige_r;
  reg [1:0]  prio_r;
  reg        ndesc_r;
  reg        cd_r;
  reg        swt_r;
  reg        err_r;
  reg        pend_r;
  reg [1:0]  state_r;
  reg [15:0] idx_r;
  reg        last_r;
  reg        blk_r;
  reg [3:0]  blk_cnt_r;
  reg [1:0]  tro_cnt_r;
  reg        trig_m_r;
  reg        trig_s_r;
  reg        trig_d_r;
  reg        wr_pend_r;
  reg        rd_pend_r;
  reg [7:0]  bus_ofs_r;

  wire [31:0] ctl    = dctl_r[cd_r];
  wire [31:0] src    = src_r[cd_r];
  wire [31:0] dst    = dst_r[cd_r];
  wire [1:0]  esize  = ctl[`DCE_D_ESIZE];
  wire [1:0]  ttype  = ctl[`DCE_D_TTYPE];
  wire [1:0]  mode   = ctl[`DCE_D_MODE];
  wire        busy   = (state_r != S_IDLE);
  wire        lvl    = (ttype == `DCE_TT_LVL4) ||
                       (ttype == `DCE_TT_LVL8);
  wire [3:0]  wait_n = (ttype == `DCE_TT_LVL8) ?
                       `DCE_WAIT_LVL8 : `DCE_WAIT_LVL4;

  // Pulse types act on a rising edge only, so a trigger still high after
  // a transfer never re-fires them
  wire hw_ev = trige_r && !blk_r &&
               ((trig_s_r && !trig_d_r) ||
                (lvl && trig_s_r && !busy));
  wire trig_ev = swt_r || hw_ev;

  wire beaten = arb_req_i &&
                ((arb_prio_i < prio_r) ||
                 ((arb_prio_i == prio_r) &&
                  (arb_chan_i < CHAN_ID)));

  wire [31:0] src_shift = ctl[`DCE_D_SWORD] ? 32'h0 :
                          {27'h0, src[1:0], 3'h0};
  wire [31:0] dst_shift = ctl[`DCE_D_DWORD] ? 32'h0 :
                          {27'h0, dst[1:0], 3'h0};
  // Narrow element taken from its byte lane, or the low lanes of a word
  wire [31:0] elem = (mem_rdata_i >> src_shift) & dce_mask(esize);
  wire [31:0] src_inc = src + {29'h0,
                        dce_step(esize, ctl[`DCE_D_SWORD])};
  wire [31:0] dst_inc = dst + {29'h0,
                        dce_step(esize, ctl[`DCE_D_DWORD])};
  wire chain_eff = ctl[`DCE_D_CHAIN] ||
                   (mode == `DCE_MD_CHAIN);

  wire bus_go = hsel_i && htrans_i[1] && hready_i;

  // ----------------------------------------
  // Trigger synchroniser
  // ----------------------------------------
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_m_r <= 1'b0;
      trig_s_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      trig_m_r <= trigger_input_i;
      trig_s_r <= trig_m_r;
      trig_d_r <= trig_s_r;
    end
  end

  // ----------------------------------------
  // Register file, bus slave and transfer engine
  // ----------------------------------------
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_r[0]    <= 32'h0;
      src_r[1]    <= 32'h0;
      dst_r[0]    <= 32'h0;
      dst_r[1]    <= 32'h0;
      dctl_r[0]   <= `DCE_DCTL_RST;
      dctl_r[1]   <= `DCE_DCTL_RST;
      en_r        <= 1'b0;
      trige_r     <= 1'b0;
      prio_r      <= `DCE_PRIO_RST;
      ndesc_r     <= 1'b0;
      cd_r        <= 1'b0;
      swt_r       <= 1'b0;
      err_r       <= 1'b0;
      pend_r      <= 1'b0;
      state_r     <= S_IDLE;
      idx_r       <= 16'h0;
      last_r      <= 1'b0;
      blk_r       <= 1'b0;
      blk_cnt_r   <= 4'h0;
      tro_cnt_r   <= 2'h0;
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      bus_ofs_r   <= 8'h0;
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      completion_trigger_output_o <= 1'b0;
      irq_req_o   <= 1'b0;
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= 32'h0;
      mem_size_o  <= 2'h0;
      mem_wdata_o <= 32'h0;
    end else begin
      swt_r     <= 1'b0;
      irq_req_o <= 1'b0;
      // Bus address phase; reads take one wait state so that a read
      // right after a write sees the written value
      wr_pend_r <= bus_go && hwrite_i;
      rd_pend_r <= bus_go && !hwrite_i;
      if (bus_go) begin
        bus_ofs_r   <= haddr_i[7:0];
        hreadyout_o <= hwrite_i;
      end else begin
        hreadyout_o <= 1'b1;
      end
      if (rd_pend_r) begin
        if (bus_ofs_r == `DCE_OFS_CTRL)
          hrdata_o <= {26'h0, cd_r, ndesc_r, prio_r, trige_r, en_r};
        else if (bus_ofs_r == `DCE_OFS_STAT)
          hrdata_o <= {idx_r, 11'h0, err_r, cd_r, pend_r, busy, en_r};
        else if (bus_ofs_r == `DCE_OFS_SRC0)
          hrdata_o <= src_r[0];
        else if (bus_ofs_r == `DCE_OFS_DST0)
          hrdata_o <= dst_r[0];
        else if (bus_ofs_r == `DCE_OFS_DCTL0)
          hrdata_o <= dctl_r[0];
        else if (bus_ofs_r == `DCE_OFS_SRC1)
          hrdata_o <= src_r[1];
        else if (bus_ofs_r == `DCE_OFS_DST1)
          hrdata_o <= dst_r[1];
        else if (bus_ofs_r == `DCE_OFS_DCTL1)
          hrdata_o <= dctl_r[1];
        else
          hrdata_o <= 32'h0;
      end
      if (wr_pend_r) begin
        if (bus_ofs_r == `DCE_OFS_CTRL) begin
          en_r    <= hwdata_i[`DCE_CTRL_EN];
          trige_r <= hwdata_i[`DCE_CTRL_TRIGE];
          prio_r  <= hwdata_i[`DCE_CTRL_PRIO];
          ndesc_r <= hwdata_i[`DCE_CTRL_NDESC];
          swt_r   <= hwdata_i[`DCE_CTRL_SWT];
          if (!busy)
            cd_r  <= hwdata_i[`DCE_CTRL_NEXT] &
                     hwdata_i[`DCE_CTRL_NDESC];
        end else if (bus_ofs_r == `DCE_OFS_STAT) begin
          if (hwdata_i[4])
            err_r <= 1'b0;
        end else if (bus_ofs_r == `DCE_OFS_SRC0) begin
          src_r[0] <= hwdata_i;
        end else if (bus_ofs_r == `DCE_OFS_DST0) begin
          dst_r[0] <= hwdata_i;
        end else if (bus_ofs_r == `DCE_OFS_DCTL0) begin
          dctl_r[0] <= hwdata_i;
        end else if (bus_ofs_r == `DCE_OFS_SRC1) begin
          src_r[1] <= hwdata_i;
        end else if (bus_ofs_r == `DCE_OFS_DST1) begin
          dst_r[1] <= hwdata_i;
        end else if (bus_ofs_r == `DCE_OFS_DCTL1) begin
          dctl_r[1] <= hwdata_i;
        end
      end

      // Re-trigger hold-off after a completed transfer
      if (blk_r) begin
        blk_cnt_r <= blk_cnt_r + 4'h1;
        if (!trig_s_r || (lvl && blk_cnt_r == wait_n))
          blk_r <= 1'b0;
      end

      // Completion pulse stretcher
      if (tro_cnt_r != 2'h0)
        tro_cnt_r <= tro_cnt_r - 2'h1;
      completion_trigger_output_o <= (tro_cnt_r != 2'h0);

      // Extra triggers while busy fold into one pending flag
      if (trig_ev && (busy || beaten))
        pend_r <= 1'b1;

      case (state_r)
        S_IDLE: begin
          if (en_r && (pend_r || trig_ev) && !beaten) begin
            pend_r <= 1'b0;
            if (!ctl[`DCE_D_VALID]) begin
              en_r  <= 1'b0;
              err_r <= 1'b1;
            end else begin
              state_r    <= S_RD;
              mem_req_o  <= 1'b1;
              mem_we_o   <= 1'b0;
              mem_addr_o <= src;
              mem_size_o <= ctl[`DCE_D_SWORD] ?
                            `DCE_SZ_WORD : esize;
            end
          end
        end
        S_RD: begin
          if (mem_ack_i) begin
            state_r     <= S_WR;
            mem_we_o    <= 1'b1;
            mem_addr_o  <= dst;
            mem_size_o  <= ctl[`DCE_D_DWORD] ?
                           `DCE_SZ_WORD : esize;
            mem_wdata_o <= elem << dst_shift;
          end
        end
        S_WR: begin
          if (mem_ack_i) begin
            state_r   <= S_NEXT;
            mem_req_o <= 1'b0;
            mem_we_o  <= 1'b0;
            if (ctl[`DCE_D_SINC])
              src_r[cd_r] <= src_inc;
            if (ctl[`DCE_D_DINC])
              dst_r[cd_r] <= dst_inc;
            last_r <= (idx_r == ctl[`DCE_D_CNT]);
            idx_r  <= idx_r + 16'h1;
          end
        end
        default: begin
          if (last_r) begin
            state_r   <= S_IDLE;
            idx_r     <= 16'h0;
            tro_cnt_r <= `DCE_TRO_CYC;
            blk_r     <= trig_s_r;
            blk_cnt_r <= 4'h1;
            if (ctl[`DCE_D_INVAL])
              dctl_r[cd_r][`DCE_D_VALID] <= 1'b0;
            if (ctl[`DCE_D_IRQ])
              irq_req_o <= 1'b1;
            if (chain_eff && ndesc_r)
              cd_r <= ~cd_r;
            if (mode == `DCE_MD_CHAIN)
              pend_r <= 1'b1;
          end else if (mode == `DCE_MD_SINGLE) begin
            state_r   <= S_IDLE;
            tro_cnt_r <= `DCE_TRO_CYC;
            blk_r     <= trig_s_r;
            blk_cnt_r <= 4'h1;
          end else if (ctl[`DCE_D_PREEMPT] && beaten) begin
            state_r <= S_IDLE;
            pend_r  <= 1'b1;
          end else begin
            state_r    <= S_RD;
            mem_req_o  <= 1'b1;
            mem_addr_o <= src;
            mem_size_o <= ctl[`DCE_D_SWORD] ?
                          `DCE_SZ_WORD : esize;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: dce_channel_checker.sv
// Port-level assertions for the DMA channel
`timescale 1ns/10ps
`default_nettype none
module dce_channel_checker (
  // Clock, reset and register bus
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  // Event outputs and memory side
  input wire logic        completion_trigger_output_o,
  input wire logic        irq_req_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [1:0]  mem_size_o,
  input wire logic        mem_ack_i
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire tk   = hsel_i & htrans_i[1] & hready_i;
  wire wack = mem_req_o & mem_we_o & mem_ack_i;
  // Cycles since the last write ack, saturating so reset never fakes one
  logic [3:0] since_r;
  always @(posedge core_clk_i or negedge reset_n_i)
    if (!reset_n_i)
      since_r <= 4'hf;
    else if (wack)
      since_r <= 4'h0;
    else if (since_r != 4'hf)
      since_r <= since_r + 4'h1;
  AST_RD_WAIT: assert property (tk && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (tk && hwrite_i |=> hreadyout_o)
    else $error("write stalled");
  AST_TRO_TWO: assert property ($rose(completion_trigger_output_o) |=>
    completion_trigger_output_o ##1 !completion_trigger_output_o)
    else $error("completion pulse not two cycles");
  AST_TRO_CAUSE: assert property (
    $rose(completion_trigger_output_o) |-> since_r inside {[1:5]})
    else $error("completion without write");
  AST_IRQ_ONE: assert property (
    irq_req_o |-> since_r <= 4'h5 ##1 !irq_req_o)
    else $error("irq pulse wrong");
  AST_REQ_HOLD: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) &&
    $stable(mem_size_o))
    else $error("memory request changed before ack");
  AST_RD_WR: assert property (mem_req_o && !mem_we_o && mem_ack_i |=>
    mem_req_o && mem_we_o) else $error("read not followed by write");
  AST_WR_END: assert property (wack |=> !mem_req_o)
    else $error("request after element end");
  AST_SIZE: assert property (mem_req_o |-> mem_size_o != 2'h3)
    else $error("bad element size");
  cover property ($rose(completion_trigger_output_o));
  cover property (irq_req_o);
  cover property (wack ##1 !mem_req_o);
endmodule
bind dce_channel dce_channel_checker i_dce_channel_checker (.*);
`default_nettype wire

// file: dce_mem_model.sv
// Memory target with random ack delay and write log
`timescale 1ns/10ps
`default_nettype none
module dce_mem_model (
  // Bus from the channel
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [31:0] wdata_i,
  // Answer and log
  output logic             ack_o,
  output logic [31:0]      rdata_o,
  output logic [31:0]      wr_cnt_o,
  output logic [31:0]      last_addr_o,
  output logic [31:0]      last_data_o,
  output logic [1:0]       last_size_o
);
  logic [1:0] dly_r;
  // No ack right after an ack: the channel needs that edge to move on
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      dly_r <= 2'h0;
      rdata_o <= 32'h0;
      wr_cnt_o <= 32'h0;
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o && dly_r != 2'h0)
        dly_r <= dly_r - 2'h1;
      else if (req_i && !ack_o) begin
        ack_o <= 1'b1;
        dly_r <= 2'($urandom_range(3, 0));
        rdata_o <= {~addr_i[15:0], addr_i[15:0]};
        if (we_i) begin
          wr_cnt_o <= wr_cnt_o + 32'h1;
          last_addr_o <= addr_i;
          last_data_o <= wdata_i;
          last_size_o <= size_i;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb_dce_channel.sv
// Self-checking bench for the DMA channel
`timescale 1ns/10ps
`default_nettype none
`include "dce_defines.vh"
module tb_dce_channel;
  logic        core_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic        trigger_input_i = 1'b0;
  logic        arb_req_i = 1'b0;
  logic [1:0]  arb_prio_i = 2'h0;
  logic [4:0]  arb_chan_i = 5'h1f;
  wire  [31:0] hrdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, wc, la, ld;
  wire  [1:0]  mem_size_o, ls;
  wire         hreadyout_o, hresp_o, completion_trigger_output_o, irq_req_o;
  wire         mem_req_o, mem_we_o, mem_ack_i;
  wire         hready_i = hreadyout_o;
  int          bad_count = 0;
  int          checked = 0;
  int          irq_n = 0;
  int          tro_n = 0;
  logic [31:0] v, s, d, n, e, seed_v;
  dce_channel i_dce_channel (.*);
  dce_mem_model i_dce_mem_model (
    .clk_i(core_clk_i), .rst_n_i(reset_n_i), .req_i(mem_req_o),
    .we_i(mem_we_o), .addr_i(mem_addr_o), .size_i(mem_size_o),
    .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i),
    .wr_cnt_o(wc), .last_addr_o(la), .last_data_o(ld), .last_size_o(ls));
  initial forever #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (irq_req_o === 1'b1) irq_n <= irq_n + 1;
  // Cycles spent high, so one transfer must add exactly two
  always @(posedge core_clk_i)
    if (completion_trigger_output_o === 1'b1) tro_n <= tro_n + 1;
  function automatic logic [31:0] exp_w(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  // One AHB-Lite single transfer; the master never assumes a latency
  task automatic bus(input logic w, input [7:0] a, input [31:0] dat,
                     output [31:0] r);
    int k;
    k = 0;
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1 && ++k < 50);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= dat;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1 && ++k < 50);
    r = hrdata_o;
    if (k >= 50) begin
      chk(1'b0, "bus timeout");
      print_verdict();
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] dat);
    logic [31:0] r;
    bus(1'b1, a, dat, r);
  endtask
  task automatic rd(input [7:0] a, output [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask
  task automatic pulse(input int k);
    trigger_input_i <= 1'b1;
    repeat (k) @(posedge core_clk_i);
    trigger_input_i <= 1'b0;
  endtask
  task automatic wait_wr(input logic [31:0] t);
    int k;
    for (k = 0; k < 3000 && wc !== t; k++) @(posedge core_clk_i);
    if (k >= 3000) begin
      chk(1'b0, "transfer timeout");
      print_verdict();
    end
    repeat (10) @(posedge core_clk_i);
  endtask
  task automatic load(input [31:0] sa, input [31:0] da, input [31:0] ctl);
    wr(`DCE_OFS_SRC0, sa);
    wr(`DCE_OFS_DST0, da);
    wr(`DCE_OFS_DCTL0, ctl);
  endtask
  initial begin
    seed_v = $urandom(32899);
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd(`DCE_OFS_CTRL, v);
    chk(v[3:2] === `DCE_PRIO_RST && v[0] === 1'b0, "prio reset");
    rd(`DCE_OFS_DCTL0, v);
    chk(v === `DCE_DCTL_RST, "descriptor reset");
    rd(8'h0c, v);
    chk(v === 32'h0, "unmapped read");
    wr(`DCE_OFS_CTRL, 32'hd);
    pulse(3);
    repeat (12) @(posedge core_clk_i);
    // An accepted trigger would hit the invalid descriptor and drop enable
    rd(`DCE_OFS_STAT, v);
    chk(wc === 32'h0 && v[4:0] === 5'h01, "pin while disabled");
    s = $urandom & 32'h0ffffffc;
    d = $urandom & 32'h0ffffffc;
    load(s, d, 32'h803e0001);
    wr(`DCE_OFS_CTRL, 32'h10d);
    wait_wr(1);
    chk(la === d && ld === exp_w(s), "single element");
    chk(tro_n == 2, "completion pulse");
    rd(`DCE_OFS_SRC0, v);
    chk(v === s + 4, "source step");
    rd(`DCE_OFS_DST0, v);
    chk(v === d + 4, "destination step");
    wr(`DCE_OFS_CTRL, 32'hf);
    pulse(2);
    wait_wr(2);
    chk(la === d + 4 && ld === exp_w(s + 4), "pin trigger");
    n = $urandom_range(5, 2);
    load(s, d, 32'hb13e0000 | (n - 1));
    wr(`DCE_OFS_CTRL, 32'h10f);
    wait_wr(2 + n);
    e = s + 4 * (n - 1);
    chk(la === d + 4 * (n - 1) && ld === exp_w(e), "block");
    chk(irq_n == 1, "irq count");
    rd(`DCE_OFS_DCTL0, v);
    chk(v[31] === 1'b0, "invalidated");
    wr(`DCE_OFS_CTRL, 32'h10f);
    repeat (12) @(posedge core_clk_i);
    rd(`DCE_OFS_STAT, v);
    chk(v[4:0] === 5'h10 && wc === 2 + n, "invalid run");
    wr(`DCE_OFS_STAT, 32'h10);
    load(s, d | 2, 32'h80250000);
    wr(`DCE_OFS_CTRL, 32'h10d);
    wait_wr(3 + n);
    e = exp_w(s);
    chk(ld[31:16] === e[15:0] && ls === `DCE_SZ_HALF, "half lane");
    rd(`DCE_OFS_DST0, v);
    chk(v === (d | 2) + 2, "element width step");
    arb_req_i <= 1'b1;
    load(s, d, 32'h853e0000 | (n - 1));
    wr(`DCE_OFS_CTRL, 32'h10d);
    wr(`DCE_OFS_CTRL, 32'h10d);
    repeat (12) @(posedge core_clk_i);
    rd(`DCE_OFS_STAT, v);
    chk(v[2] === 1'b1 && wc === 3 + n, "held pending");
    arb_req_i <= 1'b0;
    wait_wr(3 + 2 * n);
    repeat (40) @(posedge core_clk_i);
    chk(wc === 3 + 2 * n && la === d + 4 * (n - 1), "one pending");
    // Rival arrives one edge after the start: first element only
    load(s, d, 32'h853e0000 | (n - 1));
    wr(`DCE_OFS_CTRL, 32'h10d);
    @(posedge core_clk_i);
    arb_req_i <= 1'b1;
    repeat (30) @(posedge core_clk_i);
    rd(`DCE_OFS_STAT, v);
    chk(v[2:1] === 2'h2 && wc === 4 + 2 * n, "preempted");
    arb_req_i <= 1'b0;
    wait_wr(3 + 3 * n);
    chk(la === d + 4 * (n - 1), "resumed");
    // Equal priority from a higher channel number must not hold us off
    arb_prio_i <= 2'h3;
    arb_req_i <= 1'b1;
    load(s, d, 32'h823e0000);
    wr(`DCE_OFS_SRC1, d);
    wr(`DCE_OFS_DST1, s);
    wr(`DCE_OFS_DCTL1, 32'h803e0000);
    wr(`DCE_OFS_CTRL, 32'h11d);
    wait_wr(5 + 3 * n);
    rd(`DCE_OFS_STAT, v);
    chk(la === s && ld === exp_w(d), "chained");
    chk(v[3] === 1'b1, "two descriptors");
    arb_req_i <= 1'b0;
    // Level held high: re-fires after the wait, then meets the invalid
    wr(`DCE_OFS_CTRL, 32'hf);
    load(s, d, 32'h907e0001);
    trigger_input_i <= 1'b1;
    wait_wr(7 + 3 * n);
    repeat (20) @(posedge core_clk_i);
    trigger_input_i <= 1'b0;
    rd(`DCE_OFS_STAT, v);
    chk(v[4:0] === 5'h10 && wc === 7 + 3 * n, "level re-trigger");
    chk(la === d + 4, "level second element");
    wr(`DCE_OFS_STAT, 32'h10);
    wr(`DCE_OFS_CTRL, 32'hf);
    load(s, d, 32'h80fe0001);
    trigger_input_i <= 1'b1;
    repeat (60) @(posedge core_clk_i);
    trigger_input_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk(wc === 8 + 3 * n, "held pulse fires once");
    pulse(2);
    wait_wr(9 + 3 * n);
    chk(la === d + 4, "fresh edge fires");
    chk(hresp_o === 1'b0, "okay response");
    print_verdict();
  end
endmodule
`default_nettype wire
